/* common/ftc_pkg.sv */
// ftc_pkg: register map, control field layout and timing constants for the fan speed monitor.
// Assumes a single hclk domain at 125 MHz; the 100 kHz reference is derived internally.
`default_nettype none
package ftc_pkg;
  // clocking
  localparam int unsigned HCLK_HZ = 125000000;
  localparam int unsigned REF_HZ = 100000;
  localparam int unsigned REF_DIV = HCLK_HZ / REF_HZ;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_HILIM = 8'h08;
  localparam logic [7:0] OFF_LOLIM = 8'h0C;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
  // control word bit positions
  localparam int unsigned B_TOG_IE = 15;
  localparam int unsigned B_RDY_IE = 14;
  localparam int unsigned B_EDGE_HI = 12;
  localparam int unsigned B_EDGE_LO = 11;
  localparam int unsigned B_MODE = 10;
  localparam int unsigned B_FILT = 8;
  localparam int unsigned B_EN = 1;
  localparam int unsigned B_LIM_IE = 0;
  // writable control bits; reserved 13, 9, 7..2 stay zero
  localparam logic [15:0] CTRL_WMASK = 16'hDD03;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // status bit positions
  localparam int unsigned S_RDY = 3;
  localparam int unsigned S_TOG = 2;
  localparam int unsigned S_PIN = 1;
  localparam int unsigned S_LIM = 0;
  // edges per measurement for codes 00,01,10,11
  localparam logic [3:0] EDGES_0 = 4'h2;
  localparam logic [3:0] EDGES_1 = 4'h3;
  localparam logic [3:0] EDGES_2 = 4'h5;
  localparam logic [3:0] EDGES_3 = 4'h9;
  // filter: pulses shorter than this many reference periods are dropped
  localparam logic [1:0] FILT_REF_PERIODS = 2'h2;
  localparam logic [15:0] HILIM_RESET = 16'hFFFF;
  localparam logic [15:0] LOLIM_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
endpackage
`default_nettype wire

/* hw/ftc_ref_tick.sv */
// ftc_ref_tick: one-cycle tick at the reference rate derived from hclk.
// Assumes hclk is the only clock; running stops while run is low (gated block).
`default_nettype none
module ftc_ref_tick #(
  parameter int unsigned DIV = ftc_pkg::REF_DIV
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  output logic tick
);
  typedef struct packed {
    logic [10:0] cnt;
    logic tick;
  } ftc_tick_t;
  ftc_tick_t r, next_r;

  // divider holds its phase while gated, so resume continues where it stopped
  always_comb
  begin
    next_r = r;
    next_r.tick = 1'b0;
    if (run)
    begin
      if (r.cnt == 11'(DIV - 1))
      begin
        next_r.cnt = '0;
        next_r.tick = 1'b1;
      end
      else
        next_r.cnt = r.cnt + 11'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign tick = r.tick;
endmodule
`default_nettype wire

/* hw/ftc_in_sync.sv */
// ftc_in_sync: three-stage synchroniser for the fan input pin.
// Assumes the pin is asynchronous to hclk; a change counts once stages 1 and 2 agree.
`default_nettype none
module ftc_in_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic [2:0] sh;
    logic level;
  } ftc_sync_t;
  ftc_sync_t r, next_r;

  // stage 0 feeds only stage 1; stages 1 and 2 vote
  always_comb
  begin
    next_r = r;
    next_r.sh = {r.sh[1:0], pin};
    if (r.sh[1] == r.sh[2])
      next_r.level = r.sh[2];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign level = r.level;
endmodule
`default_nettype wire

/* hw/ftc_fan_tach.sv */
// ftc_fan_tach: fan speed monitor with AHB-Lite register slave and one interrupt.
// Assumes a single hclk domain at 125 MHz and an asynchronous fan tach input pin.
//
// Summary of operation
// - control bit 15 gates the input-toggle status onto the interrupt
// - control bit 14 gates the reading-ready status onto the interrupt
// - edge field bits 12:11 select 2, 3, 5 or 9 edges per measurement
// - reference mode counts reference pulses across the selected edge window
// - mode bit 10 set: count reference ticks, latch reading and clear at edge count
// - mode bit clear: count each rising edge of the fan input
// - filter bit 8 drops fan pulses shorter than two reference periods
// - enable bit 1 low stops the block and releases the fan pin
// - re-enable resumes counters and keeps earlier status pending
// - control bit 0 gates the out-of-limit flag onto the interrupt, default off
// - interrupt output is the OR of enabled status events
// - reference mode latches count and sets reading-ready at edge count
// - reference mode also latches on counter saturation, showing FFFF
`default_nettype none
module ftc_fan_tach (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic fan_tach_in,
  output logic fan_tach_ie,
  output logic irq
);
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] speed_reading;
    logic [15:0] cnt;
    logic [15:0] hi_lim;
    logic [15:0] lo_lim;
    logic rdy_flag;
    logic tog_flag;
    logic limit_violation_flag;
    logic filt_level;
    logic [1:0] filt_cnt;
    logic prev_level;
    logic [3:0] edge_cnt;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic ie;
    logic irq;
  } ftc_state_t;
  ftc_state_t r, next_r;

  logic pin_level;
  logic ref_tick;
  logic en;
  logic filt_on;
  logic mode_ref;
  logic level_used;
  logic rise;
  logic toggle;
  logic [3:0] edges_needed;
  logic rd_take;
  logic wr_take;
  logic clr_rdy;
  logic clr_tog;
  logic clr_lim;
  logic latch_now;
  logic [15:0] latch_val;

  // edge count decode for the two-bit field
  function automatic logic [3:0] edges_for(input logic [1:0] code);
    logic [3:0] n;
    n = ftc_pkg::EDGES_0;
    unique case (code)
      2'h0: n = ftc_pkg::EDGES_0;
      2'h1: n = ftc_pkg::EDGES_1;
      2'h2: n = ftc_pkg::EDGES_2;
      2'h3: n = ftc_pkg::EDGES_3;
    endcase
    return n;
  endfunction

  // register readback for one word offset
  function automatic logic [31:0] read_word(input ftc_state_t s, input logic [7:0] a,
                                            input logic pin);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      ftc_pkg::OFF_CTRL: d = {s.speed_reading, s.ctrl};
      ftc_pkg::OFF_STAT:
      begin
        d[ftc_pkg::S_RDY] = s.rdy_flag;
        d[ftc_pkg::S_TOG] = s.tog_flag;
        d[ftc_pkg::S_PIN] = pin;
        d[ftc_pkg::S_LIM] = s.limit_violation_flag;
      end
      ftc_pkg::OFF_HILIM: d = {16'h0000, s.hi_lim};
      ftc_pkg::OFF_LOLIM: d = {16'h0000, s.lo_lim};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  ftc_in_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(fan_tach_in),
    .level(pin_level)
  );

  // divider runs only while enabled: models the gated block clock
  ftc_ref_tick #(
    .DIV(ftc_pkg::REF_DIV)
  ) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(en),
    .tick(ref_tick)
  );

  // control decode
  always_comb
  begin
    en = r.ctrl[ftc_pkg::B_EN];
    filt_on = r.ctrl[ftc_pkg::B_FILT];
    mode_ref = r.ctrl[ftc_pkg::B_MODE];
    edges_needed = edges_for(r.ctrl[ftc_pkg::B_EDGE_HI:ftc_pkg::B_EDGE_LO]);
  end

  // bus request capture; every access is zero wait, so hsel, hready and htrans[1] are the only qualifiers
  always_comb
  begin
    rd_take = hsel && hready && htrans[1] && !hwrite;
    wr_take = hsel && hready && htrans[1] && hwrite;
    clr_rdy = r.wr_pend && r.wr_addr == ftc_pkg::OFF_STAT && hwdata[ftc_pkg::S_RDY];
    clr_tog = r.wr_pend && r.wr_addr == ftc_pkg::OFF_STAT && hwdata[ftc_pkg::S_TOG];
    clr_lim = r.wr_pend && r.wr_addr == ftc_pkg::OFF_STAT && hwdata[ftc_pkg::S_LIM];
  end

  // input path: filtered or raw, edges only seen while enabled
  always_comb
  begin
    level_used = filt_on ? r.filt_level : pin_level;
    rise = en && level_used && !r.prev_level;
    toggle = en && (level_used != r.prev_level);
  end

  // measurement end: edge window complete or counter saturated
  always_comb
  begin
    latch_now = 1'b0;
    latch_val = r.cnt;
    if (en && mode_ref)
    begin
      // both transitions count as edges: n edges bound n-1 half periods
      if (toggle && (r.edge_cnt + 4'h1 >= edges_needed - 4'h1))
        latch_now = 1'b1;
      else if (ref_tick && r.cnt == ftc_pkg::CNT_MAX - 16'h0001)
      begin
        latch_now = 1'b1;
        latch_val = ftc_pkg::CNT_MAX;
      end
    end
  end

  // next state for the whole block
  always_comb
  begin
    next_r = r;
    // glitch filter: new level accepted after two reference periods stable
    if (en)
    begin
      if (pin_level == r.filt_level)
        next_r.filt_cnt = '0;
      else if (ref_tick)
      begin
        if (r.filt_cnt == ftc_pkg::FILT_REF_PERIODS - 2'h1)
        begin
          next_r.filt_level = pin_level;
          next_r.filt_cnt = '0;
        end
        else
          next_r.filt_cnt = r.filt_cnt + 2'h1;
      end
      next_r.prev_level = level_used;
    end
    // counting; when disabled everything holds its value
    if (en && !mode_ref)
    begin
      if (rise)
      begin
        next_r.cnt = r.cnt + 16'h0001;
        next_r.speed_reading = r.cnt + 16'h0001;
      end
    end
    else if (en && mode_ref)
    begin
      if (latch_now)
      begin
        next_r.speed_reading = latch_val;
        next_r.cnt = '0;
        next_r.edge_cnt = '0;
      end
      else
      begin
        // every input transition is an edge; the latching edge opens the next window
        if (ref_tick)
          next_r.cnt = r.cnt + 16'h0001;
        if (toggle)
          next_r.edge_cnt = r.edge_cnt + 4'h1;
      end
    end
    // status flags: hardware set wins over software clear; held while disabled
    next_r.rdy_flag = (en && mode_ref && latch_now) || (r.rdy_flag && !clr_rdy);
    next_r.tog_flag = toggle || (r.tog_flag && !clr_tog);
    next_r.limit_violation_flag = (en && (r.speed_reading > r.hi_lim ||
                                          r.speed_reading < r.lo_lim))
                                  || (r.limit_violation_flag && !clr_lim);
    // bus data phase
    next_r.wr_pend = wr_take;
    next_r.wr_addr = haddr;
    if (rd_take)
      next_r.rdata = read_word(r, haddr, pin_level);
    if (r.wr_pend)
    begin
      unique case (r.wr_addr)
        ftc_pkg::OFF_CTRL: next_r.ctrl = hwdata[15:0] & ftc_pkg::CTRL_WMASK;
        ftc_pkg::OFF_HILIM: next_r.hi_lim = hwdata[15:0];
        ftc_pkg::OFF_LOLIM: next_r.lo_lim = hwdata[15:0];
        default: next_r.ctrl = r.ctrl;
      endcase
    end
    // pin input buffer released while the block is gated
    next_r.ie = next_r.ctrl[ftc_pkg::B_EN];
    // interrupt: OR of enabled sticky events
    next_r.irq = (next_r.tog_flag && next_r.ctrl[ftc_pkg::B_TOG_IE])
                 || (next_r.rdy_flag && next_r.ctrl[ftc_pkg::B_RDY_IE])
                 || (next_r.limit_violation_flag && next_r.ctrl[ftc_pkg::B_LIM_IE]);
  end

  // single state register; reset clears every control bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r <= '0;
      r.ctrl <= ftc_pkg::CTRL_RESET;
      r.hi_lim <= ftc_pkg::HILIM_RESET;
      r.lo_lim <= ftc_pkg::LOLIM_RESET;
    end
    else
      r <= next_r;
  end

  // slave is ready with an OKAY response in every cycle after reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = r.rdata;
  assign fan_tach_ie = r.ie;
  assign irq = r.irq;
endmodule
`default_nettype wire

/* verif/ftc_fan_model.sv */
// ftc_fan_model: square-wave fan tach source.
// Assumes the bench clock; hp is the half period in hclk cycles, 0 holds the level.
`default_nettype none
module ftc_fan_model (
  input wire logic hclk,
  input wire logic [15:0] hp,
  output logic tach
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  initial tach = 1'b0;
  // 50% duty output; a stopped fan keeps its last level
  always @(posedge hclk)
  begin
    n <= (n + 1 >= hp) ? 0 : n + 1;
    if (hp != 16'h0000 && n + 1 >= hp)
      tach <= ~tach;
  end
endmodule
`default_nettype wire

/* verif/ftc_fan_tach_checker.sv */
// ftc_checker: bus and control-word properties of the fan speed monitor.
// Assumes one hclk domain and hready tied to hreadyout.
`default_nettype none
module ftc_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic fan_tach_ie,
  input wire logic irq
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic dw;
  logic dr;
  logic [15:0] sh;
  wire tk = hsel && hready && htrans[1] && haddr == ftc_pkg::OFF_CTRL;
  // data phase of a control access; shadow holds the writable bits only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      {dw, dr, sh} <= '0;
    else
    begin
      dw <= tk && hwrite;
      dr <= tk && !hwrite;
      sh <= dw ? hwdata[15:0] & ftc_pkg::CTRL_WMASK : sh;
    end
  end
  property p_ie;
    $stable(sh[1]) |-> fan_tach_ie == sh[1];
  endproperty
  a_ie: assert property (p_ie) else $error("pin enable");
  property p_wr;
    dw |=> fan_tach_ie == $past(hwdata[1]);
  endproperty
  a_wr: assert property (p_wr) else $error("enable write");
  property p_rd;
    dr |-> hrdata[15:0] == sh;
  endproperty
  a_rd: assert property (p_rd) else $error("ctrl read");
  property p_rsv;
    dr |-> (hrdata[15:0] & ~ftc_pkg::CTRL_WMASK) == 16'h0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_msk;
    (!(sh[15] || sh[14] || sh[0]))[*2] |-> !irq;
  endproperty
  a_msk: assert property (p_msk) else $error("irq masked");
  property p_rise;
    $rose(irq) |-> (sh[15] || sh[14] || sh[0]);
  endproperty
  a_rise: assert property (p_rise) else $error("irq cause");
  property p_rdy;
    $past(hresetn) |-> hreadyout;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready");
  property p_ok;
    hresp == 1'b0;
  endproperty
  a_ok: assert property (p_ok) else $error("response");
  c_irq: cover property ($rose(irq));
  c_off: cover property ($fell(fan_tach_ie));
  c_rd: cover property (dr);
endmodule
bind ftc_fan_tach ftc_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fan_tach_ie(fan_tach_ie),
  .irq(irq));
`default_nettype wire

/* verif/ftc_fan_tach_tb.sv */
// ftc_fan_tach_tb: self-checking bench for the fan speed monitor.
// Assumes zero-wait bus answers and a reference tick of hclk/1250.
`default_nettype none
module ftc_fan_tach_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rq;
  logic hreadyout;
  logic fan;
  logic fan_tach_ie;
  logic irq;
  logic [15:0] hp = 16'h0;
  logic [15:0] r0;
  int n_mismatch = 0;
  int checks_done = 0;
  ftc_fan_tach u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .fan_tach_in(fan),
    .fan_tach_ie(fan_tach_ie), .irq(irq));
  ftc_fan_model u_fan (.hclk(hclk), .hp(hp), .tach(fan));
  // 125 MHz
  always #4 hclk = ~hclk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    checks_done++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, g, lo);
    end
  endtask
  // hready seen at the negedge is what the next rising edge samples
  task automatic wt();
    int k;
    k = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 50)
      begin
        n_mismatch++;
        conclude();
      end
      @(negedge hclk);
    end
    rq = hrdata;
    @(posedge hclk);
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
  endtask
  // bounded poll of one status bit; running out ends the run
  task automatic poll(input int b);
    rq = 32'h0;
    for (int k = 0; k < 9000 && rq[b] !== 1'b1; k++)
      xfer(ftc_pkg::OFF_STAT, 1'b0, 32'h0);
    if (rq[b] !== 1'b1)
    begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic t_regs();
    xfer(ftc_pkg::OFF_CTRL, 1'b0, 32'h0);
    chk(rq, 32'h0, 32'h0);
    xfer(ftc_pkg::OFF_CTRL, 1'b1, 32'hFFFF_FFFD);
    xfer(ftc_pkg::OFF_CTRL, 1'b0, 32'h0);
    chk(rq, 32'h0000_DD01, 32'h0000_DD01);
    xfer(8'h14, 1'b0, 32'h0);
    chk(rq, 32'h0, 32'h0);
    xfer(ftc_pkg::OFF_CTRL, 1'b1, 32'h0);
  endtask
  task automatic t_mode0();
    hp <= 16'h0BB8;
    xfer(ftc_pkg::OFF_CTRL, 1'b1, 32'h0000_8102);
    poll(2);
    chk(irq, 1, 1);
    xfer(ftc_pkg::OFF_CTRL, 1'b0, 32'h0);
    r0 = rq[31:16];
    repeat (12000) @(posedge hclk);
    xfer(ftc_pkg::OFF_CTRL, 1'b0, 32'h0);
    chk(16'(rq[31:16] - r0), 1, 3);
    xfer(ftc_pkg::OFF_CTRL, 1'b1, 32'h0000_0102);
    xfer(ftc_pkg::OFF_STAT, 1'b1, 32'h0000_000F);
    repeat (3) @(negedge hclk);
    chk(irq, 0, 0);
    // 400-cycle pulses stay well under two reference periods
    hp <= 16'h0190;
    repeat (100) @(posedge hclk);
    xfer(ftc_pkg::OFF_CTRL, 1'b0, 32'h0);
    r0 = rq[31:16];
    repeat (6000) @(posedge hclk);
    xfer(ftc_pkg::OFF_CTRL, 1'b0, 32'h0);
    chk(16'(rq[31:16] - r0), 0, 0);
    hp <= 16'h0;
  endtask
  task automatic t_limit();
    xfer(ftc_pkg::OFF_HILIM, 1'b1, 32'h0);
    xfer(ftc_pkg::OFF_CTRL, 1'b1, 32'h0000_0103);
    poll(0);
    chk(irq, 1, 1);
    xfer(ftc_pkg::OFF_CTRL, 1'b0, 32'h0);
    r0 = rq[31:16];
    xfer(ftc_pkg::OFF_CTRL, 1'b1, 32'h0000_0101);
    @(negedge hclk);
    chk(fan_tach_ie, 0, 0);
    hp <= 16'h0BB8;
    repeat (6000) @(posedge hclk);
    xfer(ftc_pkg::OFF_CTRL, 1'b0, 32'h0);
    chk(rq[31:16], r0, r0);
    // status read while still gated: the earlier event must stay pending
    xfer(ftc_pkg::OFF_STAT, 1'b0, 32'h0);
    chk(rq[0], 1, 1);
    xfer(ftc_pkg::OFF_CTRL, 1'b1, 32'h0000_0103);
    hp <= 16'h0;
    xfer(ftc_pkg::OFF_HILIM, 1'b1, 32'h0000_FFFF);
  endtask
  // reference ticks across 2, 3, 5 and 9 fan edges of a 2000-cycle half period
  task automatic t_mode1();
    int e;
    int nd[4] = '{2, 3, 5, 9};
    hp <= 16'h07D0;
    for (int c = 0; c < 4; c++)
    begin
      xfer(ftc_pkg::OFF_CTRL, 1'b1, 32'h0000_4402 | (c << 11));
      xfer(ftc_pkg::OFF_STAT, 1'b1, 32'h0000_0008);
      poll(3);
      chk(irq, 1, 1);
      xfer(ftc_pkg::OFF_STAT, 1'b1, 32'h0000_0008);
      poll(3);
      xfer(ftc_pkg::OFF_CTRL, 1'b0, 32'h0);
      e = (nd[c] - 1) * 2000 / 1250;
      chk(rq[31:16], e - 1, e + 2);
    end
  endtask
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_regs();
    t_mode0();
    t_limit();
    t_mode1();
    conclude();
  end
endmodule
`default_nettype wire
